/* File: common/tpg_pkg.sv */
// Package: constants and types shared by the process data gate
package tpg_pkg;

  // ==========================================================
  // Network states as carried in heartbeat messages
  // ==========================================================
  typedef enum logic [6:0]
  {
    TPG_NMT_BOOT    = 7'h00,
    TPG_NMT_STOPPED = 7'h04,
    TPG_NMT_OPER    = 7'h05,
    TPG_NMT_PREOP   = 7'h7F
  } tpg_nmt_t;

  // ==========================================================
  // COB-ID layout and identifier derivation
  // ==========================================================
  localparam int          TPG_COB_INVALID_BIT = 31;
  localparam int          TPG_COB_NODEDEP_BIT = 30;
  localparam int          TPG_CANID_W         = 11;
  localparam int          TPG_NODE_W          = 7;
  localparam logic [10:0] TPG_TPDO4_BASE      = 11'h480;
  localparam logic [10:0] TPG_SRDO1_BASE      = 11'h0FF;
  localparam logic [10:0] TPG_HB_BASE         = 11'h700;

  // ==========================================================
  // Transmission types
  // ==========================================================
  localparam logic [7:0] TPG_TT_SYNC_MAX  = 8'hF0;
  localparam logic [7:0] TPG_TT_EVENT_MIN = 8'hFE;

  // ==========================================================
  // Angles, 0.01 degree per bit
  // ==========================================================
  localparam int           TPG_ANG_W      = 16;
  localparam logic [15:0]  TPG_LONG_FULL  = 16'h4650;
  localparam logic [15:0]  TPG_LAT_FULL   = 16'h2328;
  localparam logic [15:0]  TPG_LIMIT_TOL  = 16'h0064;

  // ==========================================================
  // Factory values and timing
  // ==========================================================
  localparam logic [7:0]  TPG_DEF_TTYPE     = 8'hFE;
  localparam logic [15:0] TPG_DEF_EVT_MS    = 16'h000A;
  localparam logic [15:0] TPG_DEF_LIMIT     = 16'h4650;
  localparam int          TPG_CLK_MHZ       = 200;
  localparam int          TPG_MS_NS         = 1000000;
  localparam int          TPG_CLK_NS        = 5;
  localparam int          TPG_MS_CYCLES     = TPG_MS_NS / TPG_CLK_NS;

  // ==========================================================
  // Outgoing frame kinds
  // ==========================================================
  localparam logic [1:0] TPG_FR_TPDO = 2'h0;
  localparam logic [1:0] TPG_FR_SRDO = 2'h1;
  localparam logic [1:0] TPG_FR_HB   = 2'h2;

  localparam int TPG_FRAME_W = 2 + 11 + 64;

endpackage

/* File: verilog/tpg_fifo.sv */
// Module: synchronous FIFO with valid/ready on both sides
module tpg_fifo
  import tpg_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push;
  wire              pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Never more than DEPTH words held
  fifo_bound_a: assert property (@(posedge sys_clk) disable iff (rst)
    count <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");

endmodule

/* File: verilog/tpg_gate.sv */
// Module: process data gating, range clamp and parameter store for a node
module tpg_gate
  import tpg_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int MS_CYCLES  = TPG_MS_CYCLES,
  parameter int XCHK_TOL   = 16'h0032
)
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic [1:0]             nmt_cmd,
  input  wire logic                   nmt_cmd_valid,
  input  wire logic                   sync_rx,
  input  wire logic [6:0]             node_id,
  input  wire logic [31:0]            tpdo_cob,
  input  wire logic [31:0]            srdo_cob,
  input  wire logic [7:0]             cfg_ttype,
  input  wire logic [15:0]            cfg_evt_ms,
  input  wire logic [15:0]            cfg_limit,
  input  wire logic                   cfg_limited,
  input  wire logic                   cfg_wr,
  input  wire logic                   store_req,
  input  wire logic                   restore_req,
  input  wire logic [15:0]            srdo_crc_stored,
  input  wire logic [15:0]            hb_ms,
  input  wire logic [15:0]            cell_a_long,
  input  wire logic [15:0]            cell_a_lat,
  input  wire logic [15:0]            cell_b_long,
  input  wire logic [15:0]            cell_b_lat,
  input  wire logic                   sample_valid,
  output logic [TPG_FRAME_W-1:0]      frame_data,
  output logic                        frame_valid,
  input  wire logic                   frame_ready,
  output logic [6:0]                  nmt_state,
  output logic                        srdo_crc_ok,
  output logic                        nv_write,
  output logic [7:0]                  nv_ttype,
  output logic [15:0]                 nv_evt_ms,
  output logic [15:0]                 nv_limit,
  output logic                        restore_pend,
  output logic [15:0]                 ang_long,
  output logic [15:0]                 ang_lat,
  output logic [7:0]                  safe_status
);

  // ==========================================================
  // Network state
  // ==========================================================
  tpg_nmt_t state;
  wire      oper;

  assign oper      = (state == TPG_NMT_OPER);
  assign nmt_state = state;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state <= TPG_NMT_BOOT;
    end
    else if (state == TPG_NMT_BOOT)
    begin
      state <= TPG_NMT_PREOP;
    end
    else if (nmt_cmd_valid)
    begin
      case (nmt_cmd)
        2'h0:    state <= TPG_NMT_OPER;
        2'h1:    state <= TPG_NMT_STOPPED;
        2'h2:    state <= TPG_NMT_PREOP;
        default: state <= state;
      endcase
    end
  end

  // ==========================================================
  // Working parameters, non-volatile image
  // ==========================================================
  logic [7:0]  ttype;
  logic [15:0] evt_ms;
  logic [15:0] limit;

  // Defaults written to the image only; working copy untouched
  // apply after reset
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ttype  <= TPG_DEF_TTYPE;
      evt_ms <= TPG_DEF_EVT_MS;
      limit  <= TPG_DEF_LIMIT;
    end
    else if (cfg_wr)
    begin
      ttype  <= cfg_ttype;
      evt_ms <= cfg_evt_ms;
      limit  <= cfg_limit;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      nv_write     <= 1'b0;
      nv_ttype     <= TPG_DEF_TTYPE;
      nv_evt_ms    <= TPG_DEF_EVT_MS;
      nv_limit     <= TPG_DEF_LIMIT;
      restore_pend <= 1'b0;
    end
    else
    begin
      nv_write <= store_req || restore_req;
      if (restore_req)
      begin
        nv_ttype     <= TPG_DEF_TTYPE;
        nv_evt_ms    <= TPG_DEF_EVT_MS;
        nv_limit     <= TPG_DEF_LIMIT;
        restore_pend <= 1'b1;
      end
      else if (store_req)
      begin
        nv_ttype  <= ttype;
        nv_evt_ms <= evt_ms;
        nv_limit  <= limit;
      end
    end
  end

  // ==========================================================
  // Identifiers and checksum
  // ==========================================================
  wire [10:0] tpdo_id;
  wire [10:0] srdo_id;
  wire        tpdo_en;
  wire        srdo_en;
  wire [15:0] crc_calc;

  assign tpdo_id = tpdo_cob[TPG_COB_NODEDEP_BIT] ? tpdo_cob[10:0] :
                   TPG_TPDO4_BASE + {4'h0, node_id};
  assign srdo_id = srdo_cob[TPG_COB_NODEDEP_BIT] ? srdo_cob[10:0] :
                   TPG_SRDO1_BASE + {3'h0, node_id, 1'b0};
  assign tpdo_en = !tpdo_cob[TPG_COB_INVALID_BIT];
  assign srdo_en = !srdo_cob[TPG_COB_INVALID_BIT];
  assign crc_calc = {5'h00, srdo_id} ^ {ttype, ttype} ^ evt_ms
                    ^ {srdo_cob[31:24], 8'h00};
  assign srdo_crc_ok = (crc_calc == srdo_crc_stored);

  // ==========================================================
  // Angle clamp and sensor cross-check
  // ==========================================================
  function automatic logic [15:0] clamp(input logic [15:0] a,
                                       input logic [15:0] lim,
                                       input logic [15:0] full,
                                       input logic        en);
    logic signed [17:0] v;
    logic signed [17:0] hi;
    v  = 18'(signed'(a));
    hi = 18'(signed'(lim)) + 18'(signed'(TPG_LIMIT_TOL));
    if (en && v > hi)
      clamp = full;
    else if (en && v < -hi)
      clamp = 16'(-signed'(full));
    else
      clamp = a;
  endfunction

  function automatic logic differs(input logic [15:0] a,
                                   input logic [15:0] b);
    logic signed [16:0] d;
    d = 17'(signed'(a)) - 17'(signed'(b));
    differs = (d > 17'(XCHK_TOL)) || (d < -17'(XCHK_TOL));
  endfunction

  wire [15:0] next_long;
  wire [15:0] next_lat;
  wire [7:0]  next_status;

  assign next_long = clamp(cell_a_long, limit, TPG_LONG_FULL,
                           cfg_limited);
  assign next_lat  = clamp(cell_a_lat, limit, TPG_LAT_FULL,
                           cfg_limited);
  assign next_status = {6'h00,
                        differs(cell_a_lat, cell_b_lat),
                        differs(cell_a_long, cell_b_long)};

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ang_long    <= '0;
      ang_lat     <= '0;
      safe_status <= 8'h03;
    end
    else if (sample_valid)
    begin
      ang_long    <= next_long;
      ang_lat     <= next_lat;
      safe_status <= next_status;
    end
  end

  // ==========================================================
  // Triggers: event timer, SYNC, heartbeat
  // ==========================================================
  logic [31:0] evt_cnt;
  logic [31:0] hb_cnt;
  logic [7:0]  sync_cnt;
  logic        evt_fire;
  logic        hb_fire;
  logic        sync_fire;
  wire         is_sync;
  wire [31:0]  evt_len;
  wire [31:0]  hb_len;

  assign is_sync = (ttype <= TPG_TT_SYNC_MAX);
  assign evt_len = 32'(evt_ms) * 32'(MS_CYCLES);
  assign hb_len  = 32'(hb_ms) * 32'(MS_CYCLES);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      evt_cnt   <= '0;
      hb_cnt    <= '0;
      sync_cnt  <= '0;
      evt_fire  <= 1'b0;
      hb_fire   <= 1'b0;
      sync_fire <= 1'b0;
    end
    else
    begin
      evt_fire  <= 1'b0;
      hb_fire   <= 1'b0;
      sync_fire <= 1'b0;
      if (evt_ms != '0 && evt_cnt + 1 >= evt_len)
      begin
        evt_cnt  <= '0;
        evt_fire <= !is_sync;
      end
      else
      begin
        evt_cnt <= evt_cnt + 1;
      end
      if (hb_ms != '0 && hb_cnt + 1 >= hb_len)
      begin
        hb_cnt  <= '0;
        hb_fire <= 1'b1;
      end
      else
      begin
        hb_cnt <= hb_cnt + 1;
      end
      if (sync_rx && is_sync)
      begin
        if (sync_cnt + 8'h01 >= ((ttype == 8'h00) ? 8'h01 : ttype))
        begin
          sync_cnt  <= '0;
          sync_fire <= 1'b1;
        end
        else
        begin
          sync_cnt <= sync_cnt + 8'h01;
        end
      end
    end
  end

  // ==========================================================
  // Frame builder into the FIFO
  // ==========================================================
  logic              tpdo_pend;
  logic              srdo_pend;
  logic              hb_pend;
  wire               fifo_in_ready;
  wire               fifo_push;
  logic [TPG_FRAME_W-1:0] next_frame;
  wire               send_tpdo;
  wire               send_srdo;
  wire [39:0]        srdo_vals;

  assign send_tpdo = tpdo_pend && oper && tpdo_en;
  assign send_srdo = srdo_pend && oper && srdo_en && srdo_crc_ok;
  assign srdo_vals = {safe_status, ang_lat, ang_long};

  always_comb
  begin
    next_frame = '0;
    if (hb_pend)
    begin
      next_frame = {TPG_FR_HB, TPG_HB_BASE + {4'h0, node_id},
                    56'h0, 1'b0, state};
    end
    else if (send_srdo)
    begin
      // values, then inverted check part
      // Only 24 bits left, so the check covers the low bytes
      next_frame = {TPG_FR_SRDO, srdo_id, ~srdo_vals[23:0], srdo_vals};
    end
    else if (send_tpdo)
    begin
      next_frame = {TPG_FR_TPDO, tpdo_id, 24'h0, srdo_vals};
    end
  end

  assign fifo_push = (hb_pend || send_srdo || send_tpdo);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tpdo_pend <= 1'b0;
      srdo_pend <= 1'b0;
      hb_pend   <= 1'b0;
    end
    else
    begin
      hb_pend <= hb_fire || (hb_pend && !fifo_in_ready);
      if (evt_fire || sync_fire)
      begin
        tpdo_pend <= 1'b1;
        srdo_pend <= 1'b1;
      end
      else
      begin
        if (!hb_pend && fifo_in_ready && send_srdo)
          srdo_pend <= 1'b0;
        else if (!oper)
          srdo_pend <= 1'b0;
        if (!hb_pend && !send_srdo && fifo_in_ready && send_tpdo)
          tpdo_pend <= 1'b0;
        else if (!oper)
          tpdo_pend <= 1'b0;
      end
    end
  end

  tpg_fifo #(
    .WIDTH (TPG_FRAME_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_data   (next_frame),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .out_data  (frame_data),
    .out_valid (frame_valid),
    .out_ready (frame_ready)
  );

  // ==========================================================
  // Checks
  // ==========================================================
  sequence preop_push_s;
    fifo_push && next_frame[TPG_FRAME_W-1 -: 2] != TPG_FR_HB;
  endsequence

  preop_silent_a: assert property (@(posedge sys_clk) disable iff (rst)
    preop_push_s |-> oper)
    else $error("data pushed outside operational");

  srdo_crc_a: assert property (@(posedge sys_clk) disable iff (rst)
    fifo_push && !hb_pend && next_frame[76:75] == TPG_FR_SRDO
    |-> srdo_crc_ok)
    else $error("safety frame without checksum match");

  srdo_check_a: assert property (@(posedge sys_clk) disable iff (rst)
    send_srdo && !hb_pend |-> next_frame[63:40] == ~next_frame[23:0])
    else $error("safety check part wrong");

  cob_invalid_a: assert property (@(posedge sys_clk) disable iff (rst)
    fifo_push && next_frame[76:75] == TPG_FR_TPDO |-> !tpdo_cob[31])
    else $error("disabled object sent");

  clamp_long_a: assert property (@(posedge sys_clk) disable iff (rst)
    sample_valid && cfg_limited &&
    $signed(cell_a_long) > $signed(limit) + 17'sd100
    |=> ang_long == TPG_LONG_FULL)
    else $error("longitudinal not clamped");

  pass_lat_a: assert property (@(posedge sys_clk) disable iff (rst)
    sample_valid && !cfg_limited |=> ang_lat == $past(cell_a_lat))
    else $error("lateral altered without limit");

  hb_state_a: assert property (@(posedge sys_clk) disable iff (rst)
    fifo_push && hb_pend |-> next_frame[6:0] == state)
    else $error("heartbeat state wrong");

  // restore does not change working set
  restore_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    restore_req && !cfg_wr |=> limit == $past(limit))
    else $error("restore applied before reset");

  xchk_a: assert property (@(posedge sys_clk) disable iff (rst)
    sample_valid && cell_a_long == cell_b_long |=> !safe_status[0])
    else $error("equal cells flagged");

endmodule

/* File: verif/tpg_master_model.sv */
// Bus master model: takes frames from the node and sorts them by kind
module tpg_master_model
  import tpg_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic [TPG_FRAME_W-1:0] frame_data,
  input  wire logic                   frame_valid,
  input  wire logic                   stall,
  output logic                        frame_ready,
  output logic [TPG_FRAME_W-1:0]      last_tpdo,
  output logic [TPG_FRAME_W-1:0]      last_srdo,
  output logic [TPG_FRAME_W-1:0]      last_hb,
  output int                          n_tpdo,
  output int                          n_srdo,
  output int                          n_hb
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Acceptance
  // ==========================================================
  // A stalled master lets the node's queue fill up
  assign frame_ready = !stall;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      n_tpdo <= 0;
      n_srdo <= 0;
      n_hb   <= 0;
    end
    else if (frame_valid && frame_ready)
    begin
      if (frame_data[76:75] == TPG_FR_TPDO)
      begin
        last_tpdo <= frame_data;
        n_tpdo    <= n_tpdo + 1;
      end
      else if (frame_data[76:75] == TPG_FR_SRDO)
      begin
        last_srdo <= frame_data;
        n_srdo    <= n_srdo + 1;
      end
      else
      begin
        last_hb <= frame_data;
        n_hb    <= n_hb + 1;
      end
    end
  end
endmodule

/* File: verif/tpg_gate_tb.sv */
// Testbench for the process data gate
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tpg_gate_tb;
  import tpg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Stimulus and wiring
  // ==========================================================
  logic sys_clk = 0, rst = 1, nmt_cmd_valid = 0, sync_rx = 0, cfg_wr = 0;
  logic store_req = 0, restore_req = 0, sample_valid = 0, cfg_limited = 1;
  logic stall = 0;
  logic [1:0]  nmt_cmd = 2'h0;
  logic [6:0]  node_id = 7'h05;
  logic [31:0] tpdo_cob = 32'h00000000, srdo_cob = 32'h00000000;
  logic [7:0]  cfg_ttype = 8'hFE;
  logic [15:0] cfg_evt_ms = 16'h0002, cfg_limit = 16'h1770;
  // Checksum for node 5 defaults: id 109 ^ ttype FEFE ^ timer 000A
  logic [15:0] crc_st = 16'hFFFD, hb_ms = 16'h0000;
  logic [15:0] a_long = 0, a_lat = 0, b_long = 0, b_lat = 0;
  logic [TPG_FRAME_W-1:0] frame_data, last_tpdo, last_srdo, last_hb;
  logic        frame_valid, frame_ready, srdo_crc_ok, nv_write, restore_pend;
  logic [6:0]  nmt_state;
  logic [7:0]  nv_ttype, safe_status, st_same;
  logic [15:0] nv_evt_ms, nv_limit, ang_long, ang_lat;
  int          n_tpdo, n_srdo, n_hb, base, mismatches = 0, checks_done = 0;

  always #2.5 sys_clk = ~sys_clk;

  tpg_gate #(.MS_CYCLES(10)) uut (
    .sys_clk(sys_clk), .rst(rst), .nmt_cmd(nmt_cmd),
    .nmt_cmd_valid(nmt_cmd_valid), .sync_rx(sync_rx), .node_id(node_id),
    .tpdo_cob(tpdo_cob), .srdo_cob(srdo_cob), .cfg_ttype(cfg_ttype),
    .cfg_evt_ms(cfg_evt_ms), .cfg_limit(cfg_limit),
    .cfg_limited(cfg_limited), .cfg_wr(cfg_wr), .store_req(store_req),
    .restore_req(restore_req), .srdo_crc_stored(crc_st), .hb_ms(hb_ms),
    .cell_a_long(a_long), .cell_a_lat(a_lat), .cell_b_long(b_long),
    .cell_b_lat(b_lat), .sample_valid(sample_valid),
    .frame_data(frame_data), .frame_valid(frame_valid),
    .frame_ready(frame_ready), .nmt_state(nmt_state),
    .srdo_crc_ok(srdo_crc_ok), .nv_write(nv_write), .nv_ttype(nv_ttype),
    .nv_evt_ms(nv_evt_ms), .nv_limit(nv_limit),
    .restore_pend(restore_pend), .ang_long(ang_long), .ang_lat(ang_lat),
    .safe_status(safe_status));

  tpg_master_model far (
    .sys_clk(sys_clk), .rst(rst), .frame_data(frame_data),
    .frame_valid(frame_valid), .stall(stall), .frame_ready(frame_ready),
    .last_tpdo(last_tpdo), .last_srdo(last_srdo), .last_hb(last_hb),
    .n_tpdo(n_tpdo), .n_srdo(n_srdo), .n_hb(n_hb));

  // ==========================================================
  // Helpers
  // ==========================================================
  task complete_run();
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  function int cnt(input int k);
    return (k == 0) ? n_tpdo : (k == 1) ? n_srdo : n_hb;
  endfunction

  // Bounded wait for one more frame of kind k
  task wait_frame(input int k, input int lim);
    int b0;
    b0 = cnt(k);
    for (int i = 0; i <= lim; i++)
    begin
      if (cnt(k) > b0)
        return;
      @(posedge sys_clk);
    end
    mismatches++;
    complete_run();
  endtask

  task nmt(input logic [1:0] c);
    @(posedge sys_clk);
    nmt_cmd       <= c;
    nmt_cmd_valid <= 1'b1;
    @(posedge sys_clk);
    nmt_cmd_valid <= 1'b0;
    cyc(3);
  endtask

  // One sample on both cells, result judged one cycle later
  task sample(input logic [15:0] l, t, dl, el, et);
    @(posedge sys_clk);
    a_long       <= l;
    a_lat        <= t;
    b_long       <= l + dl;
    b_lat        <= t;
    sample_valid <= 1'b1;
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    @(negedge sys_clk);
    `CHK(ang_long, el)
    `CHK(ang_lat, et)
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task preop_silent();
    `CHK(nmt_state, TPG_NMT_PREOP)
    cyc(300);
    `CHK(n_tpdo + n_srdo, 0)
  endtask

  task oper_ids();
    nmt(2'h0);
    wait_frame(0, 400);
    `CHK(last_tpdo[74:64], TPG_TPDO4_BASE + 11'h005)
    `CHK(n_srdo > 0, 1'b1)
    `CHK(last_srdo[74:64], TPG_SRDO1_BASE + 11'h00A)
    `CHK(last_srdo[63:40], ~last_srdo[23:0])
    node_id <= 7'h12;
    cyc(5);
    base = n_srdo;
    wait_frame(0, 400);
    `CHK(last_tpdo[74:64], TPG_TPDO4_BASE + 11'h012)
    `CHK(srdo_crc_ok, 1'b0)
    `CHK(n_srdo, base)
    // Stalled master: frames must queue, not vanish
    stall <= 1'b1;
    cyc(150);
    `CHK(frame_valid, 1'b1)
    base = n_tpdo;
    stall <= 1'b0;
    wait_frame(0, 50);
  endtask

  task invalid_cob();
    tpdo_cob <= 32'h80000000;
    cyc(20);
    base = n_tpdo;
    cyc(300);
    `CHK(n_tpdo, base)
    tpdo_cob <= 32'h00000000;
  endtask

  task sync_only();
    @(posedge sys_clk);
    cfg_ttype <= 8'h01;
    cfg_wr    <= 1'b1;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
    cyc(20);
    base = n_tpdo;
    cyc(300);
    `CHK(n_tpdo, base)
    sync_rx <= 1'b1;
    @(posedge sys_clk);
    sync_rx <= 1'b0;
    wait_frame(0, 30);
  endtask

  task heartbeat();
    hb_ms <= 16'h0001;
    wait_frame(2, 40);
    `CHK(last_hb[74:64], TPG_HB_BASE + 11'h012)
    `CHK(last_hb[6:0], TPG_NMT_OPER)
    nmt(2'h2);
    cyc(20);
    base = n_tpdo + n_srdo;
    wait_frame(2, 40);
    `CHK(last_hb[6:0], TPG_NMT_PREOP)
    cyc(200);
    `CHK(n_tpdo + n_srdo, base)
    hb_ms <= 16'h0000;
  endtask

  task store_restore();
    `CHK(nv_ttype, TPG_DEF_TTYPE)
    @(posedge sys_clk);
    store_req <= 1'b1;
    @(posedge sys_clk);
    store_req <= 1'b0;
    @(negedge sys_clk);
    `CHK({nv_write, nv_ttype, nv_limit}, {1'b1, 8'h01, 16'h1770})
    @(negedge sys_clk);
    `CHK(nv_write, 1'b0)
    @(posedge sys_clk);
    restore_req <= 1'b1;
    @(posedge sys_clk);
    restore_req <= 1'b0;
    @(negedge sys_clk);
    `CHK({nv_ttype, nv_evt_ms}, {TPG_DEF_TTYPE, TPG_DEF_EVT_MS})
    `CHK({nv_limit, restore_pend}, {TPG_DEF_LIMIT, 1'b1})
  endtask

  task clamp();
    // Limit 60.00 deg still applies: restore waits for reset
    sample(16'h17D4, 16'hE82C, 16'h0, 16'h17D4, 16'hE82C);
    sample(16'h17D5, 16'hE82B, 16'h0, TPG_LONG_FULL, 16'hDCD8);
    sample(16'hE82B, 16'h17D5, 16'h0, 16'hB9B0, TPG_LAT_FULL);
    sample(16'hE82B, 16'hEC78, 16'h0, 16'hB9B0, 16'hEC78);
    // Unlimited unit passes values beyond the limit
    @(posedge sys_clk);
    cfg_limited <= 1'b0;
    sample(16'h17D5, 16'hE82B, 16'h0, 16'h17D5, 16'hE82B);
    @(posedge sys_clk);
    cfg_limited <= 1'b1;
    st_same = safe_status;
    sample(16'h0100, 16'h0000, 16'h0064, 16'h0100, 16'h0000);
    `CHK({st_same, safe_status}, {8'h00, 8'h01})
  endtask

  task reset_again();
    @(posedge sys_clk);
    rst <= 1'b1;
    cyc(16);
    rst <= 1'b0;
    cyc(3);
    `CHK({restore_pend, nmt_state}, {1'b0, TPG_NMT_PREOP})
    // Default limit of 180 deg now in force
    sample(16'h17D5, 16'hE82B, 16'h0, 16'h17D5, 16'hE82B);
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    cyc(16);
    rst <= 1'b0;
    cyc(3);
    preop_silent();
    oper_ids();
    invalid_cob();
    sync_only();
    heartbeat();
    store_restore();
    clamp();
    reset_again();
    complete_run();
  end
endmodule
